// >>> hw/idmm_data_memory.sv
`include "idmm_params.svh"
module idmm_data_memory #(
  parameter int RAM_DEPTH = `IDMM_RAM_DEPTH
) (
  input  wire logic                 clk,         // core clock
  input  wire logic                 sys_rst,     // sync reset, high
  input  wire logic                 reqValid,    // request offered
  input  idmm_pkg::idmm_req_s       req,         // request fields
  output logic                      reqReady,    // request taken
  output logic                      rspValid_ff, // answer pulse
  output logic      [7:0]           rspData_ff,  // byte read
  output logic                      rspBit_ff,   // bit read
  output logic      [15:0]          rspRet_ff,   // popped address
  output idmm_pkg::idmm_fnr_s       extFnr,      // outside register port
  input  wire logic                 extClaim,    // outside reg exists
  input  wire logic [7:0]           extRdData    // outside reg value
);
  ////////////////////////////////////////////////////////////////////////
  // storage and state
  logic [7:0] ram_ff  [RAM_DEPTH];
  logic [7:0] nxt_ram [RAM_DEPTH];
  idmm_pkg::idmm_st_e state_ff, nxt_state;
  logic [7:0]  savedHi_ff, nxt_savedHi;
  logic        nxt_rspValid;
  logic [7:0]  nxt_rspData;
  logic        nxt_rspBit;
  logic [15:0] nxt_rspRet;

  logic        accept;
  logic [1:0]  bank;
  logic [7:0]  stkValue;
  logic [7:0]  stkPlus;
  logic [7:0]  ptrAddr;
  logic [7:0]  regIdx;
  logic [7:0]  bitByte;
  logic [2:0]  bitIdx;
  logic [7:0]  target;
  logic        isFnr;
  logic        doWr;
  logic        isBitOp;
  logic [7:0]  fnrRdAddr;
  logic [7:0]  intData;
  logic        intHit;
  logic [7:0]  fnrByte;
  logic [7:0]  readByte;
  logic [7:0]  newByte;
  logic        ramWe;
  logic        intWe;
  logic        stkInc;
  logic        stkDec;

  assign reqReady = (state_ff == idmm_pkg::ST_IDLE);
  assign accept   = reqValid && reqReady;
  assign stkPlus  = stkValue + `IDMM_STEP;

  ////////////////////////////////////////////////////////////////////////
  // address resolution
  // bank n sits at 8n..8n+7; pointer regs are entries 0 and 1
  assign regIdx  = {3'h0, bank, req.addr[2:0]};
  assign ptrAddr = ram_ff[{3'h0, bank, 2'h0, req.addr[0]}];
  assign bitIdx  = req.addr[2:0];
  // upper bit addresses can only land on x0h/x8h registers
  assign bitByte = req.addr[7] ? {req.addr[7:3], 3'h0}
                 : (`IDMM_BITRAM_BASE | {4'h0, req.addr[6:3]});

  always_comb begin
    target  = req.addr;
    isFnr   = 1'b0;
    doWr    = 1'b0;
    isBitOp = 1'b0;
    stkInc  = 1'b0;
    stkDec  = 1'b0;
    newByte = req.wrData;
    if (state_ff == idmm_pkg::ST_CALL2) begin
      target  = stkPlus;
      doWr    = 1'b1;
      stkInc  = 1'b1;
      newByte = savedHi_ff;
    end else if (state_ff == idmm_pkg::ST_RET2) begin
      target = stkValue;
      stkDec = 1'b1;
    end else if (accept) begin
      case (req.op)
        idmm_pkg::OP_DIR_RD, idmm_pkg::OP_DIR_WR: begin
          target = req.addr;
          isFnr  = (req.addr >= `IDMM_FNR_BASE);
          doWr   = (req.op == idmm_pkg::OP_DIR_WR);
        end
        idmm_pkg::OP_IND_RD, idmm_pkg::OP_IND_WR: begin
          target = ptrAddr;
          doWr   = (req.op == idmm_pkg::OP_IND_WR);
        end
        idmm_pkg::OP_REG_RD, idmm_pkg::OP_REG_WR: begin
          target = regIdx;
          doWr   = (req.op == idmm_pkg::OP_REG_WR);
        end
        idmm_pkg::OP_BIT_RD, idmm_pkg::OP_BIT_WR: begin
          target  = bitByte;
          isFnr   = req.addr[7];
          isBitOp = 1'b1;
          doWr    = (req.op == idmm_pkg::OP_BIT_WR);
        end
        idmm_pkg::OP_PUSH, idmm_pkg::OP_CALL: begin
          target = stkPlus;
          doWr   = 1'b1;
          stkInc = 1'b1;
          if (req.op == idmm_pkg::OP_CALL) begin
            newByte = req.retAddr[7:0];
          end
        end
        idmm_pkg::OP_POP, idmm_pkg::OP_RET: begin
          target = stkValue;
          stkDec = 1'b1;
        end
        default: begin
          target = req.addr;
        end
      endcase
    end
    if (isBitOp) begin
      newByte = readByte;
      newByte[bitIdx] = req.bitVal;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register space read and write
  assign fnrRdAddr = target;

  idmm_fnr_core idmm_fnr_core_i (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .rdAddr   (fnrRdAddr),
    .rdData   (intData),
    .rdHit    (intHit),
    .wrEn     (intWe),
    .wrData   (newByte),
    .stkInc   (stkInc),
    .stkDec   (stkDec),
    .stkValue (stkValue),
    .bankSel  (bank)
  );

  // nothing answers an empty address, so it floats to ones
  assign fnrByte  = intHit ? intData
                  : (extClaim ? extRdData : `IDMM_UNIMPL);
  assign readByte = isFnr ? fnrByte : ram_ff[target];
  assign ramWe    = doWr && !isFnr && !sys_rst;
  assign intWe    = doWr && isFnr && intHit;

  // empty addresses keep no copy here; the write only goes out
  assign extFnr.addr   = target;
  assign extFnr.we     = doWr && isFnr && !intHit && !sys_rst;
  assign extFnr.wrData = newByte;

  ////////////////////////////////////////////////////////////////////////
  // scratch-pad storage
  for (genvar i = 0; i < RAM_DEPTH; i++) begin : g_ram
    assign nxt_ram[i] = (ramWe && target == 8'(i)) ? newByte : ram_ff[i];
  end

  always_ff @(posedge clk) begin
    ram_ff <= nxt_ram;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing and answer
  always_comb begin
    nxt_state    = state_ff;
    nxt_savedHi  = savedHi_ff;
    nxt_rspValid = 1'b0;
    nxt_rspData  = rspData_ff;
    nxt_rspBit   = rspBit_ff;
    nxt_rspRet   = rspRet_ff;
    if (sys_rst) begin
      nxt_state   = idmm_pkg::ST_IDLE;
      nxt_savedHi = 8'h00;
      nxt_rspData = 8'h00;
      nxt_rspBit  = 1'b0;
      nxt_rspRet  = 16'h0000;
    end else begin
      case (state_ff)
        idmm_pkg::ST_IDLE: begin
          if (accept) begin
            nxt_rspData = readByte;
            nxt_rspBit  = readByte[bitIdx];
            if (req.op == idmm_pkg::OP_CALL) begin
              nxt_savedHi = req.retAddr[15:8];
              nxt_state   = idmm_pkg::ST_CALL2;
            end else if (req.op == idmm_pkg::OP_RET) begin
              nxt_rspRet[15:8] = readByte;
              nxt_state        = idmm_pkg::ST_RET2;
            end else begin
              nxt_rspValid = 1'b1;
            end
          end
        end
        idmm_pkg::ST_CALL2: begin
          nxt_rspValid = 1'b1;
          nxt_state    = idmm_pkg::ST_IDLE;
        end
        idmm_pkg::ST_RET2: begin
          nxt_rspRet[7:0] = readByte;
          nxt_rspData     = readByte;
          nxt_rspValid    = 1'b1;
          nxt_state       = idmm_pkg::ST_IDLE;
        end
        default: begin
          nxt_state = idmm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state_ff    <= nxt_state;
    savedHi_ff  <= nxt_savedHi;
    rspValid_ff <= nxt_rspValid;
    rspData_ff  <= nxt_rspData;
    rspBit_ff   <= nxt_rspBit;
    rspRet_ff   <= nxt_rspRet;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic rstSeen_ff;
  always_ff @(posedge clk) begin
    rstSeen_ff <= sys_rst;
  end

  stk_reset_a: assert property (rstSeen_ff |->
    stkValue == `IDMM_STK_RST) else $error("stack pointer not 07h");

  push_order_a: assert property (
    accept && req.op == idmm_pkg::OP_PUSH |=>
    stkValue == $past(stkPlus) && ram_ff[stkValue] == $past(req.wrData))
    else $error("push did not store at incremented pointer");

  pop_order_a: assert property (
    accept && req.op == idmm_pkg::OP_POP |=>
    rspData_ff == $past(ram_ff[stkValue]) &&
    stkValue == $past(stkValue) - `IDMM_STEP)
    else $error("pop order wrong");

  call_push_a: assert property (
    accept && req.op == idmm_pkg::OP_CALL |=>
    state_ff == idmm_pkg::ST_CALL2 ##1
    rspValid_ff && ram_ff[stkValue] == $past(req.retAddr[15:8], 2))
    else $error("call return address not pushed");

  unimpl_one_a: assert property (
    accept && req.op == idmm_pkg::OP_DIR_RD && isFnr && !intHit &&
    !extClaim |=> rspData_ff == `IDMM_UNIMPL)
    else $error("empty register did not read ones");

  // upper RAM is mostly never written, so watch the strobes, not contents
  fnr_no_ram_a: assert property (
    accept && req.op == idmm_pkg::OP_DIR_WR && req.addr[7] |->
    !ramWe && (intWe || extFnr.we))
    else $error("register write reached upper RAM");

  dir_ram_wr_a: assert property (
    accept && req.op == idmm_pkg::OP_DIR_WR && !req.addr[7] |=>
    ram_ff[$past(req.addr)] == $past(req.wrData))
    else $error("direct write did not reach RAM");

  ret_order_a: assert property (
    accept && req.op == idmm_pkg::OP_RET |-> ##2 rspValid_ff &&
    rspRet_ff == {$past(ram_ff[stkValue], 2),
                  $past(ram_ff[stkValue - `IDMM_STEP], 2)})
    else $error("return address popped in wrong order");

  bank_pick_a: assert property (
    accept && req.op == idmm_pkg::OP_DIR_WR &&
    req.addr == `IDMM_FLAGS_ADDR |=>
    bank == $past(req.wrData[`IDMM_BANK_HI:`IDMM_BANK_LO]))
    else $error("bank select does not follow flags word");

  bank_reg_a: assert property (
    accept && req.op == idmm_pkg::OP_REG_RD |=>
    rspData_ff == $past(ram_ff[{3'h0, bank, req.addr[2:0]}]))
    else $error("working register mapped wrongly");

  indirect_rd_a: assert property (
    accept && req.op == idmm_pkg::OP_IND_RD |=>
    rspData_ff == $past(ram_ff[ptrAddr]))
    else $error("indirect read used wrong pointer");

  bit_ram_a: assert property (
    accept && req.op == idmm_pkg::OP_BIT_RD && !req.addr[7] |=>
    rspBit_ff == $past(ram_ff[bitByte][bitIdx]))
    else $error("bit read from RAM wrong");

  bit_fnr_a: assert property (
    accept && req.op == idmm_pkg::OP_BIT_WR && req.addr[7] && !intHit &&
    extClaim |-> extFnr.we && extFnr.wrData[bitIdx] == req.bitVal &&
    ((extFnr.wrData ^ extRdData) & ~(`IDMM_STEP << bitIdx)) == 8'h00)
    else $error("register bit write touched other bits");

  push_cov_c: cover property (accept && req.op == idmm_pkg::OP_PUSH);

  call_cov_c: cover property (accept && req.op == idmm_pkg::OP_CALL);
  ret_cov_c: cover property (accept && req.op == idmm_pkg::OP_RET ##2
    rspValid_ff);
  bitwr_cov_c: cover property (accept && req.op == idmm_pkg::OP_BIT_WR &&
    req.addr[7]);
endmodule : idmm_data_memory

// >>> inc/idmm_params.svh
// Contract
// - 256-byte RAM by indirect address, lower 128 bytes also direct; registers direct only.
// - Four banks of eight 8-bit working registers, reached by register ops.
// - One bank active at a time, picked by bank_select_bits in flags word.
// - Working registers 0 and 1 of active bank hold indirect RAM address.
// - RAM bytes 20h to 2Fh addressable as bytes and as single bits.
// - Bit or byte access decided only by the operation type.
// - Implemented registers at addresses ending 0 or 8 allow bit access.
// - Calls and interrupt entries push the return address on RAM stack; only OP_CALL pushes here, there is no interrupt entry.
// - Stack pointer resets to 07h.
// - Software may write any value into the stack pointer.
// - Push increments pointer first, then stores at the new pointer.
// - Pop reads at current pointer first, then decrements it.
// - Direct addresses 80h-FFh reach registers, not upper RAM.
// - Unimplemented registers and bits read as ones.
// - Unassigned register addresses hold no storage; writes do nothing.
`ifndef IDMM_PARAMS_SVH
`define IDMM_PARAMS_SVH
`define IDMM_RAM_DEPTH   256
`define IDMM_FNR_BASE    8'h80
`define IDMM_BITRAM_BASE 8'h20
`define IDMM_STK_ADDR    8'h81
`define IDMM_FLAGS_ADDR  8'hD0
`define IDMM_PRIM_ADDR   8'hE0
`define IDMM_SEC_ADDR    8'hF0
`define IDMM_STK_RST     8'h07
`define IDMM_FLAGS_RST   8'h00
`define IDMM_PRIM_RST    8'h00
`define IDMM_SEC_RST     8'h00
`define IDMM_UNIMPL      8'hFF
`define IDMM_BANK_HI     4
`define IDMM_BANK_LO     3
`define IDMM_STEP        8'h01
`endif

// >>> inc/idmm_pkg.sv
package idmm_pkg;
  typedef enum logic [3:0] {
    OP_IDLE, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
    OP_REG_RD, OP_REG_WR, OP_BIT_RD, OP_BIT_WR,
    OP_PUSH, OP_POP, OP_CALL, OP_RET
  } idmm_op_e;

  typedef enum logic [1:0] {ST_IDLE, ST_CALL2, ST_RET2} idmm_st_e;

  typedef struct packed {
    idmm_op_e    op;      // operation
    logic [7:0]  addr;    // direct/bit address, reg index, pointer sel
    logic [7:0]  wrData;  // byte to write or push
    logic        bitVal;  // bit to write
    logic [15:0] retAddr; // return address for call
  } idmm_req_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       we;
    logic [7:0] wrData;
  } idmm_fnr_s;
endpackage : idmm_pkg

// >>> hw/idmm_sfr_core.sv
`include "idmm_params.svh"
module idmm_fnr_core (
  input  wire logic       clk,      // core clock
  input  wire logic       sys_rst,  // sync reset, high
  input  wire logic [7:0] rdAddr,   // register read address
  output logic      [7:0] rdData,   // read data
  output logic            rdHit,    // address is held here
  input  wire logic       wrEn,     // write strobe
  input  wire logic [7:0] wrData,   // write data, at rdAddr
  input  wire logic       stkInc,   // push step
  input  wire logic       stkDec,   // pop step
  output logic      [7:0] stkValue, // stack_top_pointer
  output logic      [1:0] bankSel   // bank_select_bits
);
  logic [7:0] stkTop_ff, flags_ff, primOp_ff, secOp_ff;
  logic [7:0] nxt_stkTop, nxt_flags, nxt_primOp, nxt_secOp;

  always_comb begin
    rdHit  = 1'b1;
    rdData = `IDMM_UNIMPL;
    case (rdAddr)
      `IDMM_STK_ADDR:   rdData = stkTop_ff;
      `IDMM_FLAGS_ADDR: rdData = flags_ff;
      `IDMM_PRIM_ADDR:  rdData = primOp_ff;
      `IDMM_SEC_ADDR:   rdData = secOp_ff;
      default:          rdHit  = 1'b0;
    endcase
  end

  always_comb begin
    nxt_stkTop = stkTop_ff;
    nxt_flags  = flags_ff;
    nxt_primOp = primOp_ff;
    nxt_secOp  = secOp_ff;
    if (sys_rst) begin
      nxt_stkTop = `IDMM_STK_RST;
      nxt_flags  = `IDMM_FLAGS_RST;
      nxt_primOp = `IDMM_PRIM_RST;
      nxt_secOp  = `IDMM_SEC_RST;
    end else begin
      if (wrEn && rdAddr == `IDMM_STK_ADDR) begin
        nxt_stkTop = wrData;
      end else if (stkInc) begin
        nxt_stkTop = stkTop_ff + `IDMM_STEP;
      end else if (stkDec) begin
        nxt_stkTop = stkTop_ff - `IDMM_STEP;
      end
      if (wrEn && rdAddr == `IDMM_FLAGS_ADDR) begin
        nxt_flags = wrData;
      end
      if (wrEn && rdAddr == `IDMM_PRIM_ADDR) begin
        nxt_primOp = wrData;
      end
      if (wrEn && rdAddr == `IDMM_SEC_ADDR) begin
        nxt_secOp = wrData;
      end
    end
  end

  always_ff @(posedge clk) begin
    stkTop_ff <= nxt_stkTop;
    flags_ff  <= nxt_flags;
    primOp_ff <= nxt_primOp;
    secOp_ff  <= nxt_secOp;
  end

  assign stkValue = stkTop_ff;
  assign bankSel  = flags_ff[`IDMM_BANK_HI:`IDMM_BANK_LO];
endmodule : idmm_fnr_core

// >>> verif/idmm_ext_regs.sv
module idmm_ext_regs (
  input  wire logic          clk,     // core clock
  input  wire logic          sys_rst, // sync reset, high
  input  idmm_pkg::idmm_fnr_s fnr,    // outside register port
  output logic               claim,   // address held here
  output logic      [7:0]    rdData   // read value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] portReg_ff;
  logic [7:0] nxt_portReg;
  logic [3:0] modeReg_ff;
  logic [3:0] nxt_modeReg;
  logic [7:0] junk_ff;

  ////////////////////////////////////////////////////////////////////////////
  // two registers only: 80h full byte, 88h low nibble
  always_comb begin
    nxt_portReg = portReg_ff;
    nxt_modeReg = modeReg_ff;
    if (fnr.we && fnr.addr == 8'h80) nxt_portReg = fnr.wrData;
    if (fnr.we && fnr.addr == 8'h88) nxt_modeReg = fnr.wrData[3:0];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      portReg_ff <= 8'hFF;
      modeReg_ff <= 4'h0;
      junk_ff    <= 8'h00;
    end else begin
      portReg_ff <= nxt_portReg;
      modeReg_ff <= nxt_modeReg;
      junk_ff    <= ~junk_ff + 8'h03;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unclaimed reads see a changing pattern so a lazy design cannot pass
  assign claim = (fnr.addr == 8'h80) || (fnr.addr == 8'h88);
  always_comb begin
    case (fnr.addr)
      8'h80:   rdData = portReg_ff;
      8'h88:   rdData = {4'hF, modeReg_ff};
      default: rdData = junk_ff;
    endcase
  end
endmodule : idmm_ext_regs

// >>> verif/tb_internal_data_memory_map.sv
module tb_internal_data_memory_map;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                reqValid = 1'b0;
  idmm_pkg::idmm_req_s req = '0;
  logic                reqReady;
  logic                rspValid_ff;
  logic                rspBit_ff;
  logic                extClaim;
  logic [7:0]          rspData_ff;
  logic [7:0]          extRdData;
  logic [15:0]         rspRet_ff;
  idmm_pkg::idmm_fnr_s extFnr;
  int                  mismatches = 0;
  int                  comparisons = 0;

  always #4 clk = ~clk;

  idmm_data_memory idmm_data_memory_i (
    .clk(clk), .sys_rst(sys_rst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid_ff(rspValid_ff), .rspData_ff(rspData_ff),
    .rspBit_ff(rspBit_ff), .rspRet_ff(rspRet_ff), .extFnr(extFnr),
    .extClaim(extClaim), .extRdData(extRdData)
  );

  idmm_ext_regs idmm_ext_regs_i (
    .clk(clk), .sys_rst(sys_rst), .fnr(extFnr), .claim(extClaim),
    .rdData(extRdData)
  );

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task chkByte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte

  task chkRet(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkRet

  // one idle cycle between ops keeps reqValid to one assignment per step
  task automatic op(input idmm_pkg::idmm_op_e o, input logic [7:0] a,
                    input logic [7:0] d = 8'h00, input logic bv = 1'b0,
                    input logic [15:0] r = 16'h0000);
    int n;
    n = 0;
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{op: o, addr: a, wrData: d, bitVal: bv, retAddr: r};
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    // the second cycle of a two-step op must refuse new requests
    if (o == idmm_pkg::OP_CALL || o == idmm_pkg::OP_RET) begin
      chkByte({7'h00, reqReady}, 8'h00);
    end
    while (rspValid_ff !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask : op

  task wr(input logic [7:0] a, input logic [7:0] d);
    op(idmm_pkg::OP_DIR_WR, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    op(idmm_pkg::OP_DIR_RD, a);
    chkByte(rspData_ff, e);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h81, 8'h07);
    rd(8'hD0, 8'h00);
    rd(8'hE0, 8'h00);
    rd(8'hF0, 8'h00);
    wr(8'hE0, 8'hC3);
    rd(8'hE0, 8'hC3);
    wr(8'hF0, 8'h3C);
    rd(8'hF0, 8'h3C);
    wr(8'h80, 8'h5A);
    rd(8'h80, 8'h5A);
    wr(8'h88, 8'h05);
    rd(8'h88, 8'hF5);
    wr(8'h84, 8'h12);
    rd(8'h84, 8'hFF);
    op(idmm_pkg::OP_REG_WR, 8'h00, 8'h80);
    op(idmm_pkg::OP_IND_WR, 8'h00, 8'h77);
    op(idmm_pkg::OP_IND_RD, 8'h00);
    chkByte(rspData_ff, 8'h77);
    rd(8'h80, 8'h5A);
    op(idmm_pkg::OP_REG_WR, 8'h01, 8'hFE);
    op(idmm_pkg::OP_IND_WR, 8'h01, 8'h66);
    op(idmm_pkg::OP_IND_RD, 8'h01);
    chkByte(rspData_ff, 8'h66);
    for (int k = 0; k < 4; k++) begin
      wr(8'hD0, 8'(k << 3));
      op(idmm_pkg::OP_REG_WR, 8'h07, 8'(8'h10 + k));
    end
    for (int k = 0; k < 4; k++) begin
      rd(8'(8 * k + 7), 8'(8'h10 + k));
    end
    wr(8'hD0, 8'h08);
    op(idmm_pkg::OP_REG_RD, 8'h07);
    chkByte(rspData_ff, 8'h11);
    wr(8'h0B, 8'h99);
    wr(8'h21, 8'h00);
    op(idmm_pkg::OP_BIT_WR, 8'h0B, 8'h00, 1'b1);
    rd(8'h21, 8'h08);
    op(idmm_pkg::OP_BIT_RD, 8'h0B);
    chkByte({7'h00, rspBit_ff}, 8'h01);
    op(idmm_pkg::OP_BIT_RD, 8'h0C);
    chkByte({7'h00, rspBit_ff}, 8'h00);
    rd(8'h0B, 8'h99);
    op(idmm_pkg::OP_BIT_WR, 8'hE2, 8'h00, 1'b1);
    rd(8'hE0, 8'hC7);
    op(idmm_pkg::OP_BIT_WR, 8'h80, 8'h00, 1'b1);
    rd(8'h80, 8'h5B);
    wr(8'h81, 8'h30);
    rd(8'h81, 8'h30);
    op(idmm_pkg::OP_PUSH, 8'h00, 8'hA5);
    rd(8'h81, 8'h31);
    rd(8'h31, 8'hA5);
    op(idmm_pkg::OP_CALL, 8'h00, 8'h00, 1'b0, 16'h1234);
    rd(8'h81, 8'h33);
    rd(8'h32, 8'h34);
    rd(8'h33, 8'h12);
    op(idmm_pkg::OP_RET, 8'h00);
    chkRet(rspRet_ff, 16'h1234);
    rd(8'h81, 8'h31);
    op(idmm_pkg::OP_POP, 8'h00);
    chkByte(rspData_ff, 8'hA5);
    rd(8'h81, 8'h30);
    wr(8'h81, 8'hFF);
    op(idmm_pkg::OP_PUSH, 8'h00, 8'h4E);
    rd(8'h00, 8'h4E);
    report_and_stop();
  end

  // about 130 cycles of traffic after reset expected; nearly forty times that means a hang
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : tb_internal_data_memory_map
